// ==== dsdb_bank.sv ====
// Purpose: Read-only status and display parameter bank of a drive.
// Assumes: Pins pass two flip-flops; other inputs share clk.
// Notes: Parameters are read by number; writes are refused.
// Function
// - Process value is frequency times factor, limited.
// - Digit zero codes the active start source.
// - Digit one codes the active speed source.
// - Input overrides replace the configured sources.
// - Terminal bits: forward, reverse, stop, brake.
// - Stop present permits start; absent stops drive.
// - Terminal bits show pin levels and brakeOn only.
// - Four digital inputs map to bits 0-3.
// - Serial bits: receive, transmit, option, error.
// - Run time counts powered time, 10 h units.
// - Test point returns selected internal value.
// - Loop input as 0.1 % from 4 mA.
// - Power factor angle 0.0 to 180.0 degrees.
// - Output power 0.01 kW up to twice rating.
// - Firmware version 1.00 to 99.99.
// - Status bit one means true or on.
// - A 32-bit value spans two parameter numbers.
`timescale 1ns/1ps
`default_nettype none
module dsdb_bank
  import dsdb_pkg::*;
#(
  parameter int TP_SOURCES = 8,
  parameter logic [15:0] RATED_POWER = 16'h0100,
  parameter logic [15:0] FW_VERSION = 16'h0190,
  parameter longint unsigned RUN_UNIT_CYCLES = dsdb_pkg::RUN_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] paramNumber,
  input wire logic paramRead,
  input wire logic paramWrite,
  output logic [15:0] paramData,
  output logic paramAck,
  output logic paramError,
  input wire logic [15:0] outputFreq,
  input wire logic [15:0] process_scale_factor,
  input wire logic [3:0] start_source_setting,
  input wire logic [3:0] speed_reference_setting,
  input wire logic startOverride,
  input wire logic [3:0] startOverrideCode,
  input wire logic speedOverride,
  input wire logic [3:0] speedOverrideCode,
  input wire logic runFwdPin,
  input wire logic runRevPin,
  input wire logic stopPin,
  input wire logic brakeOn,
  input wire logic [3:0] digitalInPins,
  input wire logic serialRx,
  input wire logic serialTx,
  input wire logic optionAttached,
  input wire logic commErrorEvent,
  input wire logic commErrorClear,
  input wire logic powerOn,
  input wire logic [2:0] test_point_select,
  input wire logic [16*TP_SOURCES-1:0] testPointSources,
  input wire logic [15:0] loopMicroamps,
  input wire logic [15:0] outputPowerRaw,
  input wire logic [15:0] pfAngleRaw,
  output logic startPermit,
  output logic driveStopRequest
);

  // Refuse shapes that the selector and limits cannot serve.
  initial
  begin
    if (TP_SOURCES < 1 || TP_SOURCES > 8)
      $error("dsdb_bank: TP_SOURCES must be 1 to 8");
    if (FW_VERSION < FW_VERSION_MIN || FW_VERSION > FW_VERSION_MAX)
      $error("dsdb_bank: FW_VERSION out of range");
    if (RATED_POWER > 16'h7fff)
      $error("dsdb_bank: RATED_POWER too large");
  end

  // Twice the rated power, the output power ceiling.
  localparam logic [15:0] POWER_MAX = {RATED_POWER[14:0], 1'b0};

  // Two-stage synchronisers for every pin: fwd, rev, stop, dig 0..3.
  localparam int PINS = 7;
  logic [PINS-1:0] pinRaw;
  logic [PINS-1:0] pinMeta;
  logic [PINS-1:0] pinSync;
  assign pinRaw = {digitalInPins, stopPin, runRevPin, runFwdPin};

  // One synchroniser per pin; the first stage feeds only the second.
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          pinMeta[gi] <= 1'b0;
          pinSync[gi] <= 1'b0;
        end
        else
        begin
          pinMeta[gi] <= pinRaw[gi];
          pinSync[gi] <= pinMeta[gi];
        end
      end
    end
  endgenerate

  // Displayed values.
  logic [31:0] processValue;
  logic [15:0] command_source_digits;
  logic [3:0] terminal_input_status;
  logic [3:0] digital_input_status;
  logic [3:0] serial_port_status;
  logic [15:0] run_time_counter;
  logic [15:0] test_point_value;
  logic [15:0] current_loop_input_level;
  logic [15:0] output_power_value;
  logic [15:0] power_factor_angle;
  // Upper half of the process value frozen by a low-half read.
  logic [15:0] processHiHeld;

  // Full product before limiting; 0.1 Hz times 0.1 gives 0.01 units.
  logic [31:0] processProduct;
  assign processProduct = outputFreq * process_scale_factor;

  // Process value with its ceiling applied.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      processValue <= 32'h0;
    else if (processProduct > PROCESS_MAX)
      processValue <= PROCESS_MAX;
    else
      processValue <= processProduct;
  end

  // Active sources: an input override wins over the setting.
  dsdb_digit_type next_startDigit;
  dsdb_digit_type next_speedDigit;
  always_comb
  begin
    next_startDigit = startOverride ? startOverrideCode
                                    : start_source_setting;
    next_speedDigit = speedOverride ? speedOverrideCode
                                    : speed_reference_setting;
  end

  // Digit-coded source word; the two upper digits stay zero.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      command_source_digits <= 16'h0;
    else
      command_source_digits <= {8'h00,
                                next_speedDigit,
                                next_startDigit};
  end

  // Terminal status comes from the pins and brakeOn, never from serial
  // commands, so a host can see wiring faults under remote control.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      terminal_input_status <= 4'h0;
    else
    begin
      terminal_input_status[TERM_RUN_FWD] <= pinSync[0];
      terminal_input_status[TERM_RUN_REV] <= pinSync[1];
      terminal_input_status[TERM_STOP] <= pinSync[2];
      terminal_input_status[TERM_BRAKE] <= brakeOn;
    end
  end

  // Start permission follows the stop bit exactly.
  assign startPermit = terminal_input_status[TERM_STOP];
  assign driveStopRequest = ~terminal_input_status[TERM_STOP];

  // Digital inputs in input order.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      digital_input_status <= 4'h0;
    else
      digital_input_status <= pinSync[6:3];
  end

  // Serial status; the error bit is sticky and a new error wins
  // over a clear in the same cycle.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      serial_port_status <= 4'h0;
    else
    begin
      serial_port_status[SER_RX] <= serialRx;
      serial_port_status[SER_TX] <= serialTx;
      serial_port_status[SER_OPTION] <= optionAttached;
      if (commErrorEvent)
        serial_port_status[SER_ERROR] <= 1'b1;
      else if (commErrorClear)
        serial_port_status[SER_ERROR] <= 1'b0;
    end
  end

  // Elapsed run time.
  dsdb_run_timer #(
    .UNIT_CYCLES(RUN_UNIT_CYCLES)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .powerOn(powerOn),
    .runUnits(run_time_counter)
  );

  // Test-point selection; an out-of-range selector reads zero.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      test_point_value <= 16'h0;
    else if (int'(test_point_select) < TP_SOURCES)
      test_point_value <= testPointSources[16*test_point_select +: 16];
    else
      test_point_value <= 16'h0;
  end

  // Loop input: below 4 mA reads 0.0 %, above 20 mA reads 100.0 %.
  logic [15:0] loopAbove;
  logic [15:0] loopPermil;
  assign loopAbove = loopMicroamps - LOOP_ZERO_UA;
  assign loopPermil = loopAbove >> LOOP_STEP_SHIFT;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      current_loop_input_level <= 16'h0;
    else if (loopMicroamps < LOOP_ZERO_UA)
      current_loop_input_level <= 16'h0;
    else if (loopPermil > LOOP_MAX_PERMIL)
      current_loop_input_level <= LOOP_MAX_PERMIL;
    else
      current_loop_input_level <= loopPermil;
  end

  // Output power and angle are limited to their display ranges.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      output_power_value <= 16'h0;
      power_factor_angle <= 16'h0;
    end
    else
    begin
      output_power_value <= (outputPowerRaw > POWER_MAX) ? POWER_MAX
                            : outputPowerRaw;
      power_factor_angle <= (pfAngleRaw > PF_ANGLE_MAX) ? PF_ANGLE_MAX
                            : pfAngleRaw;
    end
  end

  // Read decode; unknown numbers answer zero with the error flag.
  logic [15:0] next_paramData;
  logic next_unmapped;
  always_comb
  begin
    next_unmapped = 1'b0;
    case (paramNumber)
      PN_PROCESS_LO: next_paramData = processValue[15:0];
      PN_PROCESS_HI: next_paramData = processHiHeld;
      PN_CMD_SOURCE: next_paramData = command_source_digits;
      PN_TERMINAL: next_paramData = {12'h000, terminal_input_status};
      PN_DIGITAL: next_paramData = {12'h000, digital_input_status};
      PN_SERIAL: next_paramData = {12'h000, serial_port_status};
      PN_FIRMWARE: next_paramData = FW_VERSION;
      PN_RUN_TIME: next_paramData = run_time_counter;
      PN_TEST_POINT: next_paramData = test_point_value;
      PN_CURRENT_LOOP: next_paramData = current_loop_input_level;
      PN_OUT_POWER: next_paramData = output_power_value;
      PN_PF_ANGLE: next_paramData = power_factor_angle;
      default:
      begin
        next_paramData = 16'h0;
        next_unmapped = 1'b1;
      end
    endcase
  end

  // A low-half read freezes the high half so the pair never tears.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      processHiHeld <= 16'h0;
    else if (paramRead && paramNumber == PN_PROCESS_LO)
      processHiHeld <= processValue[31:16];
  end

  // Answer one cycle after each request; a write stores nothing and
  // answers with the error flag so the host learns it was refused.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      paramData <= 16'h0;
      paramAck <= 1'b0;
      paramError <= 1'b0;
    end
    else
    begin
      paramAck <= paramRead | paramWrite;
      if (paramRead)
      begin
        paramData <= next_paramData;
        paramError <= next_unmapped;
      end
      else
      begin
        paramData <= 16'h0;
        paramError <= paramWrite;
      end
    end
  end

  // Process value never exceeds its ceiling.
  procLimit_a: assert property (@(posedge clk) disable iff (!resetn)
    processValue <= PROCESS_MAX)
    else $error("process value above ceiling");

  // Override code reaches digit zero one cycle later.
  startOvr_a: assert property (@(posedge clk) disable iff (!resetn)
    startOverride |=> command_source_digits[3:0] == $past(startOverrideCode))
    else $error("start override not shown");

  // Reserved digits read zero.
  cmdReserved_a: assert property (@(posedge clk) disable iff (!resetn)
    command_source_digits[15:8] == 8'h00)
    else $error("reserved digits not zero");

  // Forward pin shows after three clock edges.
  termFwd_a: assert property (@(posedge clk) disable iff (!resetn)
    ##3 terminal_input_status[TERM_RUN_FWD] == $past(runFwdPin, 3))
    else $error("forward bit does not follow pin");

  // Stop bit gates permission and stop request.
  stopGate_a: assert property (@(posedge clk) disable iff (!resetn)
    startPermit == terminal_input_status[TERM_STOP] &&
    driveStopRequest != startPermit)
    else $error("stop bit and permission disagree");

  // Digital input three lands in bit three.
  digIn_a: assert property (@(posedge clk) disable iff (!resetn)
    ##3 digital_input_status[3] == $past(digitalInPins[3], 3))
    else $error("digital input order wrong");

  // An error event sets the sticky bit even under a clear.
  commErr_a: assert property (@(posedge clk) disable iff (!resetn)
    commErrorEvent |=> serial_port_status[SER_ERROR])
    else $error("comm error bit not set");

  // Run time stays still without power and stays in range.
  runHold_a: assert property (@(posedge clk) disable iff (!resetn)
    !powerOn |=> $stable(run_time_counter) &&
    run_time_counter <= RUN_TIME_MAX)
    else $error("run time moved without power");

  // Loop and angle readings stay within their ranges.
  anaLimit_a: assert property (@(posedge clk) disable iff (!resetn)
    current_loop_input_level <= LOOP_MAX_PERMIL &&
    power_factor_angle <= PF_ANGLE_MAX)
    else $error("analog reading out of range");

  // Writes answer next cycle with the error flag and leave data zero.
  writeRef_a: assert property (@(posedge clk) disable iff (!resetn)
    paramWrite && !paramRead |=> paramAck && paramError &&
    paramData == 16'h0)
    else $error("write not refused");

endmodule
`default_nettype wire

// ==== dsdb_pkg.sv ====
// Purpose: Shared constants for the drive status and display bank.
// Assumes: 100 MHz clock; parameter numbers are 8-bit display indices.
// Notes: All values shown to the host are unsigned integers in the
// resolution noted beside each constant.
package dsdb_pkg;

  // Clock period in nanoseconds.
  localparam longint unsigned CLK_PERIOD_NS = 64'd10;
  // Run time is counted in units of this many hours.
  localparam longint unsigned RUN_UNIT_HOURS = 64'd10;
  // Clock cycles in one run-time unit, derived from the figures above.
  localparam longint unsigned RUN_UNIT_CYCLES =
    (RUN_UNIT_HOURS * 64'd3600 * 64'd1000000000) / CLK_PERIOD_NS;

  // Parameter numbers seen by the host.
  localparam logic [7:0] PN_PROCESS_LO = 8'h0a;
  localparam logic [7:0] PN_PROCESS_HI = 8'h0b;
  localparam logic [7:0] PN_CMD_SOURCE = 8'h0c;
  localparam logic [7:0] PN_TERMINAL = 8'h0d;
  localparam logic [7:0] PN_DIGITAL = 8'h0e;
  localparam logic [7:0] PN_SERIAL = 8'h0f;
  localparam logic [7:0] PN_FIRMWARE = 8'h10;
  localparam logic [7:0] PN_RUN_TIME = 8'h12;
  localparam logic [7:0] PN_TEST_POINT = 8'h13;
  localparam logic [7:0] PN_CURRENT_LOOP = 8'h15;
  localparam logic [7:0] PN_OUT_POWER = 8'h16;
  localparam logic [7:0] PN_PF_ANGLE = 8'h17;

  // Process value ceiling, 9999.00 in 0.01 units.
  localparam logic [31:0] PROCESS_MAX = 32'h000f_41dc;
  // Run-time ceiling in 10 hour units.
  localparam logic [15:0] RUN_TIME_MAX = 16'h270f;
  // Current loop: 4 mA floor in uA, 0.1 % step is 16 uA, ceiling 100.0 %.
  localparam logic [15:0] LOOP_ZERO_UA = 16'h0fa0;
  localparam int LOOP_STEP_SHIFT = 4;
  localparam logic [15:0] LOOP_MAX_PERMIL = 16'h03e8;
  // Power factor angle ceiling, 180.0 degrees in 0.1 degree steps.
  localparam logic [15:0] PF_ANGLE_MAX = 16'h0708;
  // Firmware version limits, 1.00 and 99.99 in 0.01 steps.
  localparam logic [15:0] FW_VERSION_MIN = 16'h0064;
  localparam logic [15:0] FW_VERSION_MAX = 16'h270f;

  // Terminal status bit positions.
  localparam int TERM_RUN_FWD = 0;
  localparam int TERM_RUN_REV = 1;
  localparam int TERM_STOP = 2;
  localparam int TERM_BRAKE = 3;
  // Serial status bit positions.
  localparam int SER_RX = 0;
  localparam int SER_TX = 1;
  localparam int SER_OPTION = 2;
  localparam int SER_ERROR = 3;

  // One decimal digit in a digit-coded parameter.
  typedef logic [3:0] dsdb_digit_type;

endpackage

// ==== dsdb_run_timer.sv ====
// Purpose: Elapsed run-time counter in 10 hour units.
// Assumes: powerOn is on the clk domain.
// Notes: The sub-unit prescaler is kept while power is off, so short
// runs add up instead of being lost.
`timescale 1ns/1ps
`default_nettype none
module dsdb_run_timer
  import dsdb_pkg::*;
#(
  parameter longint unsigned UNIT_CYCLES = dsdb_pkg::RUN_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic powerOn,
  output logic [15:0] runUnits
);

  // A zero or oversized unit length cannot be served by the prescaler.
  initial
  begin
    if (UNIT_CYCLES < 64'd1 || UNIT_CYCLES > 64'h3ff_ffff_ffff)
      $error("dsdb_run_timer: UNIT_CYCLES out of range");
  end

  // Cycles counted inside the present unit.
  logic [41:0] prescale;
  // Last prescaler value of a unit.
  localparam logic [41:0] LAST_CYCLE = 42'(UNIT_CYCLES - 64'd1);

  // Prescaler advances only while the drive outputs power.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prescale <= 42'h0;
    else if (powerOn)
    begin
      if (prescale == LAST_CYCLE)
        prescale <= 42'h0;
      else
        prescale <= prescale + 42'h1;
    end
  end

  // Unit count saturates at its ceiling rather than wrapping.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      runUnits <= 16'h0;
    else if (powerOn && prescale == LAST_CYCLE &&
             runUnits != RUN_TIME_MAX)
      runUnits <= runUnits + 16'h1;
  end

endmodule
`default_nettype wire

// ==== dsdb_host_model.sv ====
// Purpose: Host that reads and writes parameters of the status bank.
// Assumes: Requests launch on the falling edge and last one cycle.
// Notes: The answer wait is bounded; ok stays low if it runs out.
`timescale 1ns/1ps
`default_nettype none
module dsdb_host_model
(
  input wire logic clk,
  output logic [7:0] paramNumber,
  output logic paramRead,
  output logic paramWrite,
  input wire logic [15:0] paramData,
  input wire logic paramAck,
  input wire logic paramError
);
  // Request lines idle low from time zero.
  initial
  begin
    paramNumber = 8'h00;
    paramRead = 1'b0;
    paramWrite = 1'b0;
  end

  // One access: a one-cycle request, then the answer taken at an edge.
  // A 32-bit value is read low word first so the high word is frozen.
  task automatic access(input logic [7:0] num, input logic wr,
    output logic [15:0] data, output logic err, output logic ok);
    int i;
    ok = 1'b0;
    data = 16'h0000;
    err = 1'b0;
    @(negedge clk);
    paramNumber = num;
    paramRead = !wr;
    paramWrite = wr;
    @(negedge clk);
    paramRead = 1'b0;
    paramWrite = 1'b0;
    // A stale number would hide a bank that samples it late.
    paramNumber = ~num;
    // The first answer edge has already passed the falling edge above.
    if (paramAck === 1'b1)
    begin
      ok = 1'b1;
      data = paramData;
      err = paramError;
    end
    for (i = 0; i < 4 && !ok; i++)
    begin
      @(posedge clk);
      #1;
      if (paramAck === 1'b1)
      begin
        ok = 1'b1;
        data = paramData;
        err = paramError;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== dsdb_bank_bench.sv ====
// Purpose: Self-checking bench for the drive status bank.
// Assumes: Inputs change on the falling edge; short run-time unit.
// Notes: Expected values come from the bench functions below.
`timescale 1ns/1ps
`default_nettype none
module dsdb_bank_bench;
  import dsdb_pkg::*;
  localparam longint unsigned UNIT = 64'd10;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paramNumber;
  logic paramRead, paramWrite, paramAck, paramError;
  logic [15:0] paramData;
  logic [15:0] outputFreq = 16'h0, process_scale_factor = 16'h0;
  logic [3:0] start_source_setting = 4'h0, speed_reference_setting = 4'h0;
  logic startOverride = 1'b0, speedOverride = 1'b0;
  logic [3:0] startOverrideCode = 4'h0, speedOverrideCode = 4'h0;
  logic runFwdPin = 1'b0, runRevPin = 1'b0, stopPin = 1'b0;
  logic brakeOn = 1'b0, serialRx = 1'b0, serialTx = 1'b0;
  logic [3:0] digitalInPins = 4'h0;
  logic optionAttached = 1'b0, commErrorEvent = 1'b0;
  logic commErrorClear = 1'b0, powerOn = 1'b0;
  logic [2:0] test_point_select = 3'h0;
  logic [127:0] tpSrc = 128'h0;
  logic [15:0] loopMicroamps = 16'h0, outputPowerRaw = 16'h0;
  logic [15:0] pfAngleRaw = 16'h0;
  logic startPermit, driveStopRequest;
  integer seed = 94809;
  int fails = 0;
  int n_checks = 0;
  // Corner tables: below, at and above the power and angle limits, then a wide value; loop is below 4 mA, at 4 mA, mid-range, above 20 mA.
  logic [15:0] loopTab [4] = '{16'h0bb8, 16'h0fa0, 16'h2ee0, 16'h7530};
  logic [15:0] powTab [4] = '{16'h0123, 16'h0200, 16'h0201, 16'hffff};
  logic [15:0] angTab [4] = '{16'h0384, 16'h0708, 16'h0709, 16'hffff};

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  dsdb_bank #(.RUN_UNIT_CYCLES(UNIT)) u_dut (.clk(clk), .resetn(resetn),
    .paramNumber(paramNumber), .paramRead(paramRead),
    .paramWrite(paramWrite), .paramData(paramData), .paramAck(paramAck),
    .paramError(paramError), .outputFreq(outputFreq),
    .process_scale_factor(process_scale_factor),
    .start_source_setting(start_source_setting),
    .speed_reference_setting(speed_reference_setting),
    .startOverride(startOverride), .startOverrideCode(startOverrideCode),
    .speedOverride(speedOverride), .speedOverrideCode(speedOverrideCode),
    .runFwdPin(runFwdPin), .runRevPin(runRevPin), .stopPin(stopPin),
    .brakeOn(brakeOn), .digitalInPins(digitalInPins),
    .serialRx(serialRx), .serialTx(serialTx),
    .optionAttached(optionAttached), .commErrorEvent(commErrorEvent),
    .commErrorClear(commErrorClear), .powerOn(powerOn),
    .test_point_select(test_point_select), .testPointSources(tpSrc),
    .loopMicroamps(loopMicroamps), .outputPowerRaw(outputPowerRaw),
    .pfAngleRaw(pfAngleRaw), .startPermit(startPermit),
    .driveStopRequest(driveStopRequest));

  dsdb_host_model u_host (.clk(clk), .paramNumber(paramNumber),
    .paramRead(paramRead), .paramWrite(paramWrite),
    .paramData(paramData), .paramAck(paramAck), .paramError(paramError));

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compares one value; four-state equality so an unknown bit fails against a known one.
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One access through the host; a lost answer ends the run.
  task automatic rd(input logic [7:0] num, input logic wr,
    output logic [15:0] d, output logic e);
    logic ok;
    u_host.access(num, wr, d, e, ok);
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[FAIL] answer wait ran out");
      end_of_test();
    end
  endtask

  // Reads a number and expects that data with no error.
  task automatic chk_rd(input logic [7:0] num, input logic [15:0] exp,
    input string name);
    logic [15:0] d;
    logic e;
    rd(num, 1'b0, d, e);
    check({name, " data"}, {16'h0, d}, {16'h0, exp});
    check({name, " error"}, {31'h0, e}, 32'h0);
  endtask

  // Lets pin synchronisers and status registers catch up.
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // Scaled process value, limited at its ceiling.
  function automatic logic [31:0] exp_proc(input logic [15:0] f,
    input logic [15:0] k);
    logic [31:0] p;
    p = {16'h0, f} * {16'h0, k};
    return (p > PROCESS_MAX) ? PROCESS_MAX : p;
  endfunction

  // Loop current in 0.1 % steps above the 4 mA floor.
  function automatic logic [15:0] exp_loop(input logic [15:0] ua);
    logic [15:0] v;
    if (ua < LOOP_ZERO_UA)
      return 16'h0;
    v = (ua - LOOP_ZERO_UA) >> LOOP_STEP_SHIFT;
    return (v > LOOP_MAX_PERMIL) ? LOOP_MAX_PERMIL : v;
  endfunction

  // Plain ceiling on a display value.
  function automatic logic [15:0] clip(input logic [15:0] v,
    input logic [15:0] m);
    return (v > m) ? m : v;
  endfunction

  // Main sequence.
  initial
  begin
    logic [15:0] lo, hi, cmd, d;
    logic [31:0] r;
    logic e;
    #15;
    check("permit in reset", {31'h0, startPermit}, 32'h0);
    check("stop in reset", {31'h0, driveStopRequest}, 32'h1);
    @(negedge clk);
    resetn = 1'b1;
    chk_rd(PN_PROCESS_HI, 16'h0, "high word first");
    for (int i = 0; i < 5; i++)
    begin
      outputFreq = (i == 0) ? 16'h0 : 16'($random(seed)) & 16'h0fff;
      process_scale_factor = (i == 4) ? 16'hffff : 16'($random(seed));
      process_scale_factor = (i == 4) ? 16'hffff : process_scale_factor & 16'h00ff;
      settle();
      rd(PN_PROCESS_LO, 1'b0, lo, e);
      rd(PN_PROCESS_HI, 1'b0, hi, e);
      check("process", {hi, lo}, exp_proc(outputFreq, process_scale_factor));
    end
    // Every code in both digits as configured, then random codes overridden.
    for (int c = 0; c < 10; c++)
    begin
      start_source_setting = 4'(c);
      speed_reference_setting = 4'(9 - c);
      startOverrideCode = 4'($unsigned($random(seed)) % 10);
      speedOverrideCode = 4'($unsigned($random(seed)) % 10);
      startOverride = 1'b0;
      speedOverride = 1'b0;
      settle();
      chk_rd(PN_CMD_SOURCE, {8'h00, 4'(9 - c), 4'(c)}, "sources");
      startOverride = 1'b1;
      speedOverride = 1'b1;
      settle();
      cmd = {8'h00, speedOverrideCode, startOverrideCode};
      chk_rd(PN_CMD_SOURCE, cmd, "overridden");
    end
    rd(PN_CMD_SOURCE, 1'b1, d, e);
    check("write error", {31'h0, e}, 32'h1);
    check("write data", {16'h0, d}, 32'h0);
    chk_rd(PN_CMD_SOURCE, cmd, "after write");
    rd(8'h11, 1'b0, d, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    // Pins follow their own levels while the serial port commands.
    startOverrideCode = 4'h5;
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      {brakeOn, stopPin, runRevPin, runFwdPin} = r[3:0];
      digitalInPins = r[7:4];
      {optionAttached, serialTx, serialRx} = r[10:8];
      settle();
      chk_rd(PN_TERMINAL, {12'h0, r[3:0]}, "terminal");
      check("permit", {31'h0, startPermit}, {31'h0, r[2]});
      check("stop request", {31'h0, driveStopRequest}, {31'h0, !r[2]});
      chk_rd(PN_DIGITAL, {12'h0, r[7:4]}, "digital");
      chk_rd(PN_SERIAL, {13'h0, r[10:8]}, "serial");
    end
    commErrorEvent = 1'b1;
    @(negedge clk);
    commErrorEvent = 1'b0;
    settle();
    chk_rd(PN_SERIAL, {12'h0, 1'b1, r[10:8]}, "error kept");
    // A clear in the same cycle as a new error must lose.
    commErrorClear = 1'b1;
    commErrorEvent = 1'b1;
    @(negedge clk);
    commErrorEvent = 1'b0;
    commErrorClear = 1'b0;
    settle();
    chk_rd(PN_SERIAL, {12'h0, 1'b1, r[10:8]}, "error wins");
    commErrorClear = 1'b1;
    @(negedge clk);
    commErrorClear = 1'b0;
    settle();
    chk_rd(PN_SERIAL, {13'h0, r[10:8]}, "error cleared");
    for (int i = 0; i < 8; i++)
      tpSrc[32*(i/2) +: 32] = $random(seed);
    for (int s = 0; s < 8; s++)
    begin
      test_point_select = 3'(s);
      settle();
      chk_rd(PN_TEST_POINT, tpSrc[16*s +: 16], "test point");
    end
    for (int i = 0; i < 5; i++)
    begin
      loopMicroamps = (i < 4) ? loopTab[i] : 16'($random(seed));
      outputPowerRaw = (i < 4) ? powTab[i] : 16'($random(seed));
      pfAngleRaw = (i < 4) ? angTab[i] : 16'($random(seed));
      settle();
      chk_rd(PN_CURRENT_LOOP, exp_loop(loopMicroamps), "loop");
      chk_rd(PN_OUT_POWER, clip(outputPowerRaw, 16'h0200), "power");
      chk_rd(PN_PF_ANGLE, clip(pfAngleRaw, PF_ANGLE_MAX), "angle");
    end
    chk_rd(PN_FIRMWARE, 16'h0190, "firmware");
    // Powered time only; the partial unit must survive power-off.
    chk_rd(PN_RUN_TIME, 16'h0, "run idle");
    powerOn = 1'b1;
    repeat (35) @(negedge clk);
    powerOn = 1'b0;
    settle();
    chk_rd(PN_RUN_TIME, 16'h3, "run time");
    repeat (20) @(negedge clk);
    chk_rd(PN_RUN_TIME, 16'h3, "run held");
    powerOn = 1'b1;
    repeat (7) @(negedge clk);
    powerOn = 1'b0;
    settle();
    chk_rd(PN_RUN_TIME, 16'h4, "run partial");
    end_of_test();
  end
endmodule
`default_nettype wire
